/* logic/llx_pkg.sv */
// Shared constants and types for the load and link execute unit
package llx_pkg;
  localparam int XLEN = 32;
  localparam int FLEN = 64;
  localparam int PADDR_W = 32;
  localparam int REG_IDX_W = 5;
  localparam logic [4:0] ZERO_REG = 5'h00;
  localparam int WORD_ALIGN_LSB = 2;
  localparam int DWORD_ALIGN_LSB = 3;
  localparam int HALF_W = 16;
  localparam int SHAMT_W = 2;
  localparam logic [15:0] LOW_ZEROS = 16'h0000;
  localparam int IRQ_BITS = 4;
  localparam int IRQ_ADDR_ERR = 0;
  localparam int IRQ_XLT_FAULT = 1;
  localparam int IRQ_BUS_ERR = 2;
  localparam int IRQ_RSV_INSTR = 3;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_RESV = 4'h2;
  localparam logic [3:0] REG_CFG = 4'h3;
  localparam int CFG_NO_PAIRED = 0;
  localparam int CFG_EVA = 1;
  localparam int CFG_PRE_R6 = 2;
  localparam int CFG_FR64 = 3;
  localparam int CFG_FPU64 = 4;
  localparam logic [4:0] CFG_RESET = 5'h1a;

  typedef enum logic [2:0] {
    OP_PAIRED_LL_USER,
    OP_SCALED_ADD,
    OP_UPPER_IMM,
    OP_FP_DWORD_INDEXED,
    OP_WORD_LOAD,
    OP_FP_WORD_LOAD
  } op_t;

  typedef enum logic [1:0] {
    SEG_MAPPED_USER_KERNEL,
    SEG_UNMAPPED_USER_KERNEL,
    SEG_MAPPED_USER_SUPER_KERNEL,
    SEG_OTHER
  } seg_mode_t;

  typedef enum logic [2:0] {
    EXC_NONE,
    EXC_XLT_REFILL,
    EXC_XLT_INVALID,
    EXC_RESERVED_INSTR,
    EXC_ADDR_ERROR,
    EXC_WATCH,
    EXC_COP_UNUSABLE,
    EXC_BUS_ERROR
  } exc_t;
endpackage

/* logic/load_link_execute_unit.sv */
// Execute unit for paired linked loads, scaled add, upper immediate and word loads
// What this block does
// [R1] Paired load: low word rt, high word rd
// [R2] Paired read is one double-word atomic access
// [R3] Paired address is base register, no offset
// [R4] New paired load replaces active sequence
// [R5] Sets link flag, records aligned reservation address
// [R6] User mapping for mapped-user-kernel segments
// [R7] No action forcing remote store-conditional fail
// [R8] Present only without no-paired flag, with EVA
// [R9] Paired load exceptions: refill, invalid, RI, AE, watch, CpU
// [R10] Software never names same nonzero destination twice
// [R11] Scaled add: rs shifted by sa+1 plus rt
// [R12] Upper immediate: imm high, zeros low
// [R13] Indexed fp load ignores low three bits
// [R14] Indexed fp load defined only on 64-bit model
// [R15] Word load: base plus signed offset, sign-extend
// [R16] Pre-R6 word load misalignment raises address error
// [R17] Word load exceptions: refill, invalid, bus, AE, watch
// [R18] Fp word load fills low word only
// [R19] Pre-R6 fp word load misalignment raises address error
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module load_link_execute_unit
  import llx_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Issue
  input wire logic i_issue_valid,
  input wire op_t i_op,
  input wire logic [XLEN-1:0] i_base_val,
  input wire logic [XLEN-1:0] i_rs_val,
  input wire logic [XLEN-1:0] i_rt_val,
  input wire logic [15:0] i_imm,
  input wire logic [1:0] i_shift_amount_field,
  input wire logic [REG_IDX_W-1:0] i_low_word_dest_reg,
  input wire logic [REG_IDX_W-1:0] i_high_word_dest_reg,
  input wire logic i_kernel_mode,
  input wire logic i_cop_usable,
  input wire seg_mode_t i_seg_mode,
  output logic o_busy,
  // Translation and memory
  output logic o_mem_req,
  output logic [ADDR_W-1:0] o_mem_vaddr,
  output logic o_mem_dword,
  output logic o_mem_use_user_map,
  output logic o_mem_lock,
  input wire logic i_mem_done,
  input wire logic [FLEN-1:0] i_mem_rdata,
  input wire logic [PADDR_W-1:0] i_mem_paddr,
  input wire exc_t i_mem_exc,
  // Register file writeback
  output logic o_gpr_we,
  output logic [REG_IDX_W-1:0] o_gpr_waddr,
  output logic [XLEN-1:0] o_gpr_wdata,
  output logic o_gpr2_we,
  output logic [REG_IDX_W-1:0] o_gpr2_waddr,
  output logic [XLEN-1:0] o_gpr2_wdata,
  output logic o_fpr_we,
  output logic [REG_IDX_W-1:0] o_fpr_waddr,
  output logic [FLEN-1:0] o_fpr_wdata,
  output logic o_fpr_hi_undef,
  output logic o_exc_valid,
  output exc_t o_exc_code,
  // Reservation
  output logic [PADDR_W-1:0] o_reservation_address_reg,
  input wire logic i_link_clear,
  // Software registers
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic o_irq
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} state_t;

  function automatic logic misaligned(input logic [ADDR_W-1:0] a, input int lsb);
    misaligned = (a & ((ADDR_W'(1) << lsb) - ADDR_W'(1))) != '0;
  endfunction

  state_t state_q;
  op_t op_q;
  logic [REG_IDX_W-1:0] rt_q, rd_q;
  logic [PADDR_W-1:0] resv_q;
  logic [4:0] cfg_q;
  logic [IRQ_BITS-1:0] stat_q, mask_q, ev_d;
  logic [ADDR_W-1:0] ea_d;
  logic [XLEN-1:0] sum_d;
  logic start, reject, pre_r6;
  exc_t rej_code;

  assign pre_r6 = cfg_q[CFG_PRE_R6];
  assign o_busy = state_q == ST_WAIT;
  assign start = i_issue_valid && state_q == ST_IDLE;

  // Effective address per operation
  always_comb begin
    sum_d = XLEN'(i_rs_val << (i_shift_amount_field + 3'h1)) + i_rt_val; // R11
    case (i_op)
      OP_PAIRED_LL_USER: ea_d = ADDR_W'(i_base_val); // R3
      OP_FP_DWORD_INDEXED: ea_d = ADDR_W'(i_base_val + i_rt_val) &
                                  ~((ADDR_W'(1) << DWORD_ALIGN_LSB) - ADDR_W'(1)); // R13
      default: ea_d = ADDR_W'(i_base_val + {{HALF_W{i_imm[15]}}, i_imm}); // R15
    endcase
  end

  // Issue-time checks before memory is touched
  always_comb begin
    reject = 1'b0;
    rej_code = EXC_NONE;
    case (i_op)
      OP_PAIRED_LL_USER: begin
        if (cfg_q[CFG_NO_PAIRED] || !cfg_q[CFG_EVA]) begin // R8
          reject = 1'b1;
          rej_code = EXC_RESERVED_INSTR; // R9
        end else if (!i_cop_usable) begin
          reject = 1'b1;
          rej_code = EXC_COP_UNUSABLE; // R9
        end else if (misaligned(ea_d, DWORD_ALIGN_LSB) || i_seg_mode == SEG_OTHER) begin
          reject = 1'b1;
          rej_code = EXC_ADDR_ERROR; // R9
        end
      end
      OP_FP_DWORD_INDEXED: begin
        if (!i_cop_usable) begin
          reject = 1'b1;
          rej_code = EXC_COP_UNUSABLE;
        end
      end
      OP_WORD_LOAD, OP_FP_WORD_LOAD: begin
        if (i_op == OP_FP_WORD_LOAD && !i_cop_usable) begin
          reject = 1'b1;
          rej_code = EXC_COP_UNUSABLE;
        end else if (pre_r6 && misaligned(ea_d, WORD_ALIGN_LSB)) begin // R16 R19
          reject = 1'b1;
          rej_code = EXC_ADDR_ERROR; // R17
        end
      end
      default: begin
        reject = 1'b0;
        rej_code = EXC_NONE;
      end
    endcase
  end

  // Sequencer
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else if (start && !reject && i_op != OP_SCALED_ADD && i_op != OP_UPPER_IMM) begin
      state_q <= ST_WAIT;
    end else if (state_q == ST_WAIT && i_mem_done) begin
      state_q <= ST_IDLE;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      op_q <= OP_WORD_LOAD;
      rt_q <= ZERO_REG;
      rd_q <= ZERO_REG;
    end else if (start) begin
      op_q <= i_op;
      rt_q <= i_low_word_dest_reg;
      rd_q <= i_high_word_dest_reg;
    end
  end

  // Memory request held through the wait; one dword access keeps the pair atomic
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_mem_vaddr <= '0;
      o_mem_dword <= 1'b0;
      o_mem_use_user_map <= 1'b0;
      o_mem_lock <= 1'b0;
    end else if (start && !reject) begin
      o_mem_vaddr <= ea_d;
      o_mem_dword <= i_op == OP_PAIRED_LL_USER || i_op == OP_FP_DWORD_INDEXED; // R2
      o_mem_lock <= i_op == OP_PAIRED_LL_USER; // R2
      o_mem_use_user_map <= i_op == OP_PAIRED_LL_USER && i_kernel_mode &&
                            i_seg_mode == SEG_MAPPED_USER_KERNEL; // R6
    end
  end
  assign o_mem_req = state_q == ST_WAIT;

  // Writeback and exception report
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_gpr_we <= 1'b0;
      o_gpr_waddr <= ZERO_REG;
      o_gpr_wdata <= '0;
      o_gpr2_we <= 1'b0;
      o_gpr2_waddr <= ZERO_REG;
      o_gpr2_wdata <= '0;
      o_fpr_we <= 1'b0;
      o_fpr_waddr <= ZERO_REG;
      o_fpr_wdata <= '0;
      o_fpr_hi_undef <= 1'b0;
      o_exc_valid <= 1'b0;
      o_exc_code <= EXC_NONE;
    end else begin
      o_gpr_we <= 1'b0;
      o_gpr2_we <= 1'b0;
      o_fpr_we <= 1'b0;
      o_exc_valid <= 1'b0;
      if (start && reject) begin
        o_exc_valid <= 1'b1;
        o_exc_code <= rej_code;
      end else if (start && i_op == OP_SCALED_ADD) begin
        o_gpr_we <= 1'b1; // R11
        o_gpr_waddr <= i_high_word_dest_reg;
        o_gpr_wdata <= sum_d;
      end else if (start && i_op == OP_UPPER_IMM) begin
        o_gpr_we <= 1'b1;
        o_gpr_waddr <= i_low_word_dest_reg;
        o_gpr_wdata <= {i_imm, LOW_ZEROS}; // R12
      end else if (state_q == ST_WAIT && i_mem_done) begin
        if (i_mem_exc != EXC_NONE) begin
          o_exc_valid <= 1'b1; // R9 R17
          o_exc_code <= i_mem_exc;
        end else begin
          case (op_q)
            OP_PAIRED_LL_USER: begin
              o_gpr_we <= 1'b1; // R1
              o_gpr_waddr <= rt_q;
              o_gpr_wdata <= i_mem_rdata[XLEN-1:0];
              o_gpr2_we <= 1'b1;
              o_gpr2_waddr <= rd_q;
              o_gpr2_wdata <= i_mem_rdata[FLEN-1:XLEN];
            end
            OP_FP_DWORD_INDEXED: begin
              o_fpr_we <= 1'b1; // R13
              o_fpr_waddr <= rt_q;
              o_fpr_wdata <= i_mem_rdata;
              o_fpr_hi_undef <= !(cfg_q[CFG_FR64] && cfg_q[CFG_FPU64]); // R14
            end
            OP_FP_WORD_LOAD: begin
              o_fpr_we <= 1'b1; // R18
              o_fpr_waddr <= rt_q;
              o_fpr_wdata <= {{XLEN{1'b0}}, i_mem_rdata[XLEN-1:0]};
              o_fpr_hi_undef <= cfg_q[CFG_FPU64];
            end
            default: begin
              o_gpr_we <= 1'b1; // R15
              o_gpr_waddr <= rt_q;
              o_gpr_wdata <= i_mem_rdata[XLEN-1:0];
            end
          endcase
        end
      end
    end
  end

  // Reservation: newest paired load wins; only local state, no remote kill
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      resv_q <= '0;
    end else if (state_q == ST_WAIT && i_mem_done && i_mem_exc == EXC_NONE &&
                 op_q == OP_PAIRED_LL_USER) begin
      resv_q <= {i_mem_paddr[PADDR_W-1:DWORD_ALIGN_LSB], (DWORD_ALIGN_LSB-1)'(0), 1'b1}; // R4 R5 R7
    end else if (i_link_clear) begin
      resv_q[0] <= 1'b0;
    end
  end
  assign o_reservation_address_reg = resv_q;

  // Event status, set beats clear
  always_comb begin
    ev_d = '0;
    if (o_exc_valid) begin
      ev_d[IRQ_ADDR_ERR] = o_exc_code == EXC_ADDR_ERROR;
      ev_d[IRQ_XLT_FAULT] = o_exc_code == EXC_XLT_REFILL || o_exc_code == EXC_XLT_INVALID;
      ev_d[IRQ_BUS_ERR] = o_exc_code == EXC_BUS_ERROR;
      ev_d[IRQ_RSV_INSTR] = o_exc_code == EXC_RESERVED_INSTR;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((i_reg_wr && i_reg_addr == REG_STATUS) ?
                i_reg_wdata[IRQ_BITS-1:0] : '0)) | ev_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      mask_q <= '0;
      cfg_q <= CFG_RESET;
    end else if (i_reg_wr && i_reg_addr == REG_MASK) begin
      mask_q <= i_reg_wdata[IRQ_BITS-1:0];
    end else if (i_reg_wr && i_reg_addr == REG_CFG) begin
      cfg_q <= i_reg_wdata[4:0];
    end
  end
  assign o_irq = |(stat_q & mask_q);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        REG_STATUS: o_reg_rdata <= 32'(stat_q);
        REG_MASK: o_reg_rdata <= 32'(mask_q);
        REG_RESV: o_reg_rdata <= 32'(resv_q);
        REG_CFG: o_reg_rdata <= 32'(cfg_q);
        default: o_reg_rdata <= '0;
      endcase
    end else begin
      o_reg_rdata <= '0;
    end
  end

  // Paired load leaves the link flag set when it returns cleanly
  sequence s_paired_done;
    state_q == ST_WAIT && op_q == OP_PAIRED_LL_USER && i_mem_done && i_mem_exc == EXC_NONE;
  endsequence
  property p_link_set;
    @(posedge i_mclk) disable iff (i_sys_rst) s_paired_done |=> resv_q[0] && resv_q[2:1] == 2'h0;
  endproperty
  a_link_set: assert property (p_link_set) else $error("link flag not set"); // R5
  property p_pair_split;
    @(posedge i_mclk) disable iff (i_sys_rst) s_paired_done |=> o_gpr_we && o_gpr2_we &&
      o_gpr_waddr == rt_q && o_gpr2_waddr == rd_q;
  endproperty
  a_pair_split: assert property (p_pair_split) else $error("pair writeback wrong"); // R1
  property p_pair_atomic;
    @(posedge i_mclk) disable iff (i_sys_rst)
      o_mem_req && op_q == OP_PAIRED_LL_USER |-> o_mem_dword && o_mem_lock;
  endproperty
  a_pair_atomic: assert property (p_pair_atomic) else $error("pair not atomic"); // R2
  property p_no_offset;
    @(posedge i_mclk) disable iff (i_sys_rst)
      start && !reject && i_op == OP_PAIRED_LL_USER |=> o_mem_vaddr == $past(i_base_val);
  endproperty
  a_no_offset: assert property (p_no_offset) else $error("paired address offset"); // R3
  property p_absent;
    @(posedge i_mclk) disable iff (i_sys_rst) start && i_op == OP_PAIRED_LL_USER &&
      (cfg_q[CFG_NO_PAIRED] || !cfg_q[CFG_EVA])
      |=> o_exc_valid && o_exc_code == EXC_RESERVED_INSTR;
  endproperty
  a_absent: assert property (p_absent) else $error("paired load not refused"); // R8
  property p_upper;
    @(posedge i_mclk) disable iff (i_sys_rst)
      start && i_op == OP_UPPER_IMM |=> o_gpr_we && o_gpr_wdata == {$past(i_imm), LOW_ZEROS};
  endproperty
  a_upper: assert property (p_upper) else $error("upper immediate wrong"); // R12
  property p_scaled;
    @(posedge i_mclk) disable iff (i_sys_rst)
      start && i_op == OP_SCALED_ADD |=> o_gpr_we && !o_exc_valid && !o_busy;
  endproperty
  a_scaled: assert property (p_scaled) else $error("scaled add misbehaved"); // R11
  property p_misalign;
    @(posedge i_mclk) disable iff (i_sys_rst) start && pre_r6 && i_cop_usable &&
      (i_op == OP_WORD_LOAD || i_op == OP_FP_WORD_LOAD) && ea_d[1:0] != 2'h0
      |=> o_exc_valid && o_exc_code == EXC_ADDR_ERROR;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned load accepted"); // R16
  property p_user_map;
    @(posedge i_mclk) disable iff (i_sys_rst) start && !reject && i_op == OP_PAIRED_LL_USER &&
      i_kernel_mode && i_seg_mode == SEG_MAPPED_USER_KERNEL |=> o_mem_use_user_map;
  endproperty
  a_user_map: assert property (p_user_map) else $error("user mapping not used"); // R6
  property p_index_align;
    @(posedge i_mclk) disable iff (i_sys_rst)
      o_mem_req && op_q == OP_FP_DWORD_INDEXED |-> o_mem_vaddr[DWORD_ALIGN_LSB-1:0] == '0;
  endproperty
  a_index_align: assert property (p_index_align) else $error("indexed address unaligned"); // R13
endmodule

/* bench/mem_model.sv */
// Translation and memory model facing the execute unit
`timescale 1ns/1ps
module mem_model
  import llx_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Request side
  input wire logic i_req,
  input wire logic [31:0] i_vaddr,
  input wire logic [31:0] i_lat,
  input wire exc_t i_exc,
  // Answer side
  output logic o_done,
  output logic [63:0] o_rdata,
  output logic [31:0] o_paddr,
  output exc_t o_exc
);
  int cnt;

  // Whole pair in one beat, never half of it
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !i_req || o_done) begin
      cnt <= 0;
      o_done <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      o_done <= (cnt >= i_lat);
    end
  end

  // Data scrambled outside the done beat, so stale values never pass
  always_ff @(posedge i_mclk) begin
    if (i_req && !o_done && cnt >= i_lat) begin
      o_rdata <= {~i_vaddr, i_vaddr};
      o_paddr <= i_vaddr ^ 32'h4000_0000;
      o_exc <= i_exc;
    end else begin
      o_rdata <= i_sys_rst ? 64'h0 : ~o_rdata;
      o_paddr <= i_sys_rst ? 32'h0 : ~o_paddr;
      o_exc <= EXC_NONE;
    end
  end
endmodule

/* bench/test_load_link_execute_unit.sv */
// Self-checking bench for the load and link execute unit
`timescale 1ns/1ps
module test_load_link_execute_unit
  import llx_pkg::*;
;
  logic i_mclk, i_sys_rst, i_issue_valid, i_kernel_mode, i_cop_usable, i_link_clear;
  logic i_reg_wr, i_reg_rd, i_mem_done, o_busy, o_mem_req, o_mem_dword, o_mem_use_user_map;
  logic o_mem_lock, o_gpr_we, o_gpr2_we, o_fpr_we, o_fpr_hi_undef, o_exc_valid, o_irq;
  op_t i_op;
  seg_mode_t i_seg_mode;
  exc_t i_mem_exc, o_exc_code, exc_in;
  logic [31:0] i_base_val, i_rs_val, i_rt_val, o_mem_vaddr, i_mem_paddr, o_gpr_wdata;
  logic [31:0] o_gpr2_wdata, o_reservation_address_reg, i_reg_wdata, o_reg_rdata, rdv;
  logic [63:0] i_mem_rdata, o_fpr_wdata;
  logic [15:0] i_imm;
  logic [1:0] i_shift_amount_field;
  logic [4:0] i_low_word_dest_reg, i_high_word_dest_reg, o_gpr_waddr, o_gpr2_waddr, o_fpr_waddr;
  logic [3:0] i_reg_addr;
  int lat, failures, check_count, cyc;

  load_link_execute_unit dut (.i_mclk, .i_sys_rst, .i_issue_valid, .i_op, .i_base_val, .i_rs_val,
    .i_rt_val, .i_imm, .i_shift_amount_field, .i_low_word_dest_reg, .i_high_word_dest_reg,
    .i_kernel_mode, .i_cop_usable, .i_seg_mode, .o_busy, .o_mem_req, .o_mem_vaddr, .o_mem_dword,
    .o_mem_use_user_map, .o_mem_lock, .i_mem_done, .i_mem_rdata, .i_mem_paddr, .i_mem_exc,
    .o_gpr_we, .o_gpr_waddr, .o_gpr_wdata, .o_gpr2_we, .o_gpr2_waddr, .o_gpr2_wdata, .o_fpr_we,
    .o_fpr_waddr, .o_fpr_wdata, .o_fpr_hi_undef, .o_exc_valid, .o_exc_code,
    .o_reservation_address_reg, .i_link_clear, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .o_irq);
  mem_model mem (.i_mclk, .i_sys_rst, .i_req(o_mem_req), .i_vaddr(o_mem_vaddr), .i_lat(lat),
    .i_exc(exc_in), .o_done(i_mem_done), .o_rdata(i_mem_rdata), .o_paddr(i_mem_paddr),
    .o_exc(i_mem_exc));

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    #1;
    rdv = o_reg_rdata;
  endtask

  // Issue one op, return in the cycle its result pulse stands
  task automatic run(input op_t o, input logic [31:0] b, input logic [31:0] t,
                     input logic [15:0] im);
    @(posedge i_mclk);
    i_issue_valid <= 1'b1;
    i_op <= o;
    i_base_val <= b;
    i_rs_val <= b;
    i_rt_val <= t;
    i_imm <= im;
    @(posedge i_mclk);
    i_issue_valid <= 1'b0;
    for (int n = 0; n < 40; n++) begin
      #1;
      if (o_gpr_we || o_gpr2_we || o_fpr_we || o_exc_valid) break;
      @(posedge i_mclk);
    end
  endtask

  task automatic t_reset;
    rd(REG_CFG);
    chk("cfg", 32'h1a, rdv);
    rd(4'h9);
    chk("unmapped", 32'h0, rdv);
    chk("resv", 32'h0, o_reservation_address_reg);
  endtask

  task automatic t_paired;
    logic [31:0] b, nb, r;
    for (int s = 0; s < 3; s++) begin
      b = 32'h8000_1210 + 32'(s * 8);
      nb = ~b;
      lat = s * 3;
      @(posedge i_mclk);
      i_seg_mode <= seg_mode_t'(s);
      run(OP_PAIRED_LL_USER, b, 32'h0, 16'h0);
      chk("lo", b, o_gpr_wdata);
      chk("hi", nb, o_gpr2_wdata);
      chk("hi_dst", 5'h0c, o_gpr2_waddr);
      chk("lo_dst", 5'h03, o_gpr_waddr);
      chk("hi_we", 1'b1, o_gpr2_we);
      chk("vaddr", b, o_mem_vaddr);
      chk("dword", 1'b1, o_mem_dword);
      chk("lock", 1'b1, o_mem_lock);
      chk("umap", 64'(s == 0), o_mem_use_user_map);
      @(posedge i_mclk);
      #1;
      chk("resv", ((b ^ 32'h4000_0000) & 32'hffff_fff8) | 32'h1, o_reservation_address_reg);
    end
    r = o_reservation_address_reg;
    run(OP_PAIRED_LL_USER, 32'h8000_1204, 32'h0, 16'h0);
    chk("misalign", EXC_ADDR_ERROR, o_exc_code);
    chk("resv_kept", r, o_reservation_address_reg);
    @(posedge i_mclk);
    i_cop_usable <= 1'b0;
    run(OP_PAIRED_LL_USER, 32'h8000_1200, 32'h0, 16'h0);
    chk("cop", EXC_COP_UNUSABLE, o_exc_code);
    @(posedge i_mclk);
    i_cop_usable <= 1'b1;
    i_link_clear <= 1'b1;
    @(posedge i_mclk);
    i_link_clear <= 1'b0;
    #1;
    chk("link", r & 32'hffff_fffe, o_reservation_address_reg);
  endtask

  // Missing paired support must refuse, and the event drives the interrupt
  task automatic t_cfg;
    logic [31:0] v[2] = '{32'h1b, 32'h18};
    wr(REG_MASK, 32'h8);
    foreach (v[i]) begin
      wr(REG_CFG, v[i]);
      run(OP_PAIRED_LL_USER, 32'h8000_1300, 32'h0, 16'h0);
      chk("absent", EXC_RESERVED_INSTR, o_exc_code);
    end
    wr(REG_CFG, 32'h1a);
    chk("irq", 1'b1, o_irq);
    wr(REG_MASK, 32'h0);
    chk("irq_masked", 1'b0, o_irq);
    wr(REG_MASK, 32'h8);
    wr(REG_STATUS, 32'h8);
    chk("irq_clr", 1'b0, o_irq);
  endtask

  task automatic t_alu;
    logic [31:0] e;
    for (int s = 0; s < 4; s++) begin
      @(posedge i_mclk);
      i_shift_amount_field <= 2'(s);
      run(OP_SCALED_ADD, 32'hc000_0005, 32'h0000_0123, 16'h0);
      e = (32'hc000_0005 << (s + 1)) + 32'h123;
      chk("lsa", e, o_gpr_wdata);
      chk("lsa_exc", 1'b0, o_exc_valid);
      chk("lsa_dst", 5'h0c, o_gpr_waddr);
    end
    run(OP_UPPER_IMM, 32'h0, 32'h0, 16'hbeef);
    chk("upper", 32'hbeef_0000, o_gpr_wdata);
  endtask

  task automatic t_word;
    exc_t el[4] = '{EXC_XLT_REFILL, EXC_XLT_INVALID, EXC_BUS_ERROR, EXC_WATCH};
    lat = 1;
    run(OP_WORD_LOAD, 32'h9000_0010, 32'h0, 16'hfff0);
    chk("lw_addr", 32'h9000_0000, o_mem_vaddr);
    chk("lw_data", 32'h9000_0000, o_gpr_wdata);
    chk("idle", 2'b00, {o_busy, o_mem_req});
    wr(REG_CFG, 32'h1e);
    run(OP_WORD_LOAD, 32'h9000_0010, 32'h0, 16'h0002);
    chk("lw_align", EXC_ADDR_ERROR, o_exc_code);
    run(OP_FP_WORD_LOAD, 32'h9000_0011, 32'h0, 16'h0);
    chk("fw_align", EXC_ADDR_ERROR, o_exc_code);
    wr(REG_CFG, 32'h1a);
    foreach (el[i]) begin
      exc_in = el[i];
      run(OP_WORD_LOAD, 32'h9000_0010, 32'h0, 16'h0);
      chk("lw_exc", el[i], o_exc_code);
      chk("lw_nowr", 1'b0, o_gpr_we);
    end
    exc_in = EXC_NONE;
    rd(REG_STATUS);
    chk("status", 32'h7, rdv);
    run(OP_FP_WORD_LOAD, 32'h9000_0020, 32'h0, 16'h0004);
    chk("fw_lo", 32'h9000_0024, o_fpr_wdata[31:0]);
    chk("fw_hi", 1'b1, o_fpr_hi_undef);
    run(OP_FP_DWORD_INDEXED, 32'h2000_0100, 32'h15, 16'h0);
    chk("fd_addr", 32'h2000_0110, o_mem_vaddr);
    chk("fd_data", {32'hdfff_feef, 32'h2000_0110}, o_fpr_wdata);
    chk("fd_we", 1'b1, o_fpr_we);
    chk("fd_dst", 5'h03, o_fpr_waddr);
    chk("fd_def", 1'b0, o_fpr_hi_undef);
    wr(REG_CFG, 32'h12);
    run(OP_FP_DWORD_INDEXED, 32'h2000_0100, 32'h15, 16'h0);
    chk("fd_undef", 1'b1, o_fpr_hi_undef);
  endtask

  task automatic results;
    $display("Checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end

  initial begin
    i_sys_rst = 1'b1;
    {i_issue_valid, i_link_clear, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
    {i_base_val, i_rs_val, i_rt_val, i_imm, i_shift_amount_field} = '0;
    {i_kernel_mode, i_cop_usable} = 2'b11;
    i_op = OP_UPPER_IMM;
    i_seg_mode = SEG_MAPPED_USER_KERNEL;
    exc_in = EXC_NONE;
    i_low_word_dest_reg = 5'h03;
    i_high_word_dest_reg = 5'h0c;
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_paired();
    t_cfg();
    t_alu();
    t_word();
    results();
  end
endmodule
